// >>> src/hbgc_pkg.sv
// Purpose: constants and types of the half-bridge gate control block
// Assumes: core clock of 125 MHz; straps arrive as already resolved codes
// Notes:   all timing counts derive from the clock period below

package hbgc_pkg;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HBGC_TWO_IN,
    HBGC_ONE_IN,
    HBGC_INDEP
  } hbgc_mode_t;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int STRAP_W  = 3;
  localparam int GAIN_W   = 2;
  localparam int DT_W     = 7;
  localparam int OCP_TH_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int DT_MIN_NS     = 20;
  localparam int DT_MAX_NS     = 900;
  localparam int TCP_LOW_US    = 250;
  localparam int FLT_CLR_NS    = 8000;
  localparam int CFG_WIN_NS    = 2000;
  localparam int DT_MIN_CYC    = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_MAX_CYC    = DT_MAX_NS / CLK_PERIOD_NS;
  localparam int TCP_LOW_CYC   =
    (TCP_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_CLR_CYC   = (FLT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_WIN_CYC   = (CFG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // strap level codes
  // ----------------------------------------------------------------
  localparam logic [STRAP_W-1:0] DTM_TWO_NODT = 3'h0;
  localparam logic [STRAP_W-1:0] DTM_TWO_MIN  = 3'h1;
  localparam logic [STRAP_W-1:0] DTM_ONE_MIN  = 3'h2;
  localparam logic [STRAP_W-1:0] DTM_INDEP    = 3'h3;
  localparam logic [STRAP_W-1:0] DTM_TWO_ADJ  = 3'h4;
  localparam logic [STRAP_W-1:0] DTM_ONE_ADJ  = 3'h5;
  localparam logic [STRAP_W-1:0] IDRV_VGS_LVL = 3'h7;
  localparam logic [STRAP_W-1:0] OCP_LVL_OPEN = 3'h7;
  localparam logic [STRAP_W-1:0] OCP_EXT_NUM  = 3'h6;
  localparam logic [OCP_TH_W-1:0] OCP_EXT_BASE = 4'h7;

  localparam logic [DT_W-1:0] DT_MIN_C = DT_W'(DT_MIN_CYC);
  localparam logic [DT_W-1:0] DT_MAX_C = DT_W'(DT_MAX_CYC);
  localparam logic [DT_W-1:0] DT_ZERO  = 7'h00;

  // clamp a requested dead time into the legal window
  function automatic logic [DT_W-1:0] dt_clamp(input logic [DT_W-1:0] v);
    logic [DT_W-1:0] r;
    r = v;
    if (v < DT_MIN_C) begin
      r = DT_MIN_C;
    end else if (v > DT_MAX_C) begin
      r = DT_MAX_C;
    end
    return r;
  endfunction

endpackage

// >>> src/hbgc_dt_gate.sv
// Purpose: turn-on delay of one gate behind the opposite gate
// Assumes: opp_on_i is the registered opposite gate command
// Notes:   gate drops in the same cycle its request drops; only turn-on waits
`timescale 1ns/1ps

module hbgc_dt_gate
  import hbgc_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  // control
  input  wire logic            req_i,
  input  wire logic            opp_on_i,
  input  wire logic            vgs_mode_i,
  input  wire logic            opp_vgs_low_i,
  input  wire logic [DT_W-1:0] dt_cyc_i,
  // result
  output logic                 on_o
);

  logic [DT_W-1:0] cnt_ff;
  logic            on_ff;

  assign on_o = on_ff;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= DT_ZERO;
      on_ff  <= 1'b0;
    end else if (!req_i || opp_on_i) begin
      cnt_ff <= DT_ZERO;
      on_ff  <= 1'b0;
    end else if (vgs_mode_i) begin
      on_ff  <= on_ff | opp_vgs_low_i;
    end else if (cnt_ff >= dt_cyc_i) begin
      on_ff  <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end

endmodule

// >>> src/hbgc_top.sv
// Purpose: pwm decode, dead time, pump enable, straps and fault pin
// Assumes: straps are resolved level codes; reset only at power-up
// Notes:   gates stay off until the straps have been captured
`timescale 1ns/1ps

module hbgc_top
  import hbgc_pkg::*;
#(
  parameter int TCP_CYC     = TCP_LOW_CYC,
  parameter int CLR_CYC     = FLT_CLR_CYC,
  parameter int WIN_CYC     = CFG_WIN_CYC,
  parameter bit SHARED_PIN  = 1'b0
)
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // pwm inputs
  input  wire logic                pwm_primary_in_i,
  input  wire logic                pwm_secondary_in_i,
  // shutdown and shared pin
  input  wire logic                shutdown_in_n_i,
  input  wire logic                shared_fault_shutdown_n_i,
  // straps
  input  wire logic [STRAP_W-1:0]  deadtime_mode_strap_i,
  input  wire logic [DT_W-1:0]     deadtime_adjust_i,
  input  wire logic [STRAP_W-1:0]  gate_current_strap_a_i,
  input  wire logic [STRAP_W-1:0]  gate_current_strap_b_i,
  input  wire logic [STRAP_W-1:0]  overcurrent_threshold_strap_i,
  input  wire logic                overcurrent_threshold_pulse_i,
  input  wire logic [GAIN_W-1:0]   amp_gain_strap_i,
  // monitors
  input  wire logic                hs_vgs_low_i,
  input  wire logic                ls_vgs_low_i,
  input  wire logic                ocp_event_i,
  input  wire logic                fault_detect_i,
  // gate commands
  output logic                     high_gate_out_o,
  output logic                     low_gate_out_o,
  output logic                     trickle_pump_o,
  // configuration results
  output logic [1:0]               mode_o,
  output logic [DT_W-1:0]          deadtime_cyc_o,
  output logic                     vgs_deadtime_o,
  output logic [STRAP_W-1:0]       gate_current_a_o,
  output logic [STRAP_W-1:0]       gate_current_b_o,
  output logic [OCP_TH_W-1:0]      ocp_threshold_o,
  output logic                     hs_ocp_en_o,
  output logic                     ls_ocp_en_o,
  output logic [GAIN_W-1:0]        amp_gain_o,
  output logic                     cfg_done_o,
  // open-drain fault pin
  output logic                     fault_out_n_o,
  output logic                     fault_out_n_oe_n_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hbgc_mode_t            mode_ff;
  logic [DT_W-1:0]       dt_ff;
  logic                  vgs_ff;
  logic [STRAP_W-1:0]    ida_ff;
  logic [STRAP_W-1:0]    idb_ff;
  logic [STRAP_W-1:0]    ocp_lvl_ff;
  logic                  cfg_done_ff;
  logic [15:0]           win_cnt_ff;
  logic [1:0]            pulse_cnt_ff;
  logic                  pulse_d_ff;
  logic                  ocp_done_ff;
  logic [OCP_TH_W-1:0]   ocp_th_ff;
  logic                  hs_ocp_ff;
  logic                  ls_ocp_ff;
  logic [GAIN_W-1:0]     gain_ff;
  logic                  ocp_lat_ff;
  logic [15:0]           clr_cnt_ff;
  logic [17:0]           tcp_cnt_ff;
  logic                  tcp_ff;
  logic                  hg_ff;
  logic                  lg_ff;
  logic                  fault_oe_n_ff;
  logic                  fault_lvl_ff;

  logic                  hs_req;
  logic                  ls_req;
  logic                  hs_dt_on;
  logic                  ls_dt_on;
  logic                  kill;
  logic                  fault_any;
  logic                  both_low;
  logic                  clr_done;

  // ----------------------------------------------------------------
  // strap capture after power-up reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_ff     <= HBGC_TWO_IN;
      dt_ff       <= DT_ZERO;
      vgs_ff      <= 1'b0;
      ida_ff      <= '0;
      idb_ff      <= '0;
      ocp_lvl_ff  <= OCP_LVL_OPEN;
      cfg_done_ff <= 1'b0;
    end else if (!cfg_done_ff) begin
      cfg_done_ff <= 1'b1;
      ida_ff      <= gate_current_strap_a_i;
      idb_ff      <= gate_current_strap_b_i;
      ocp_lvl_ff  <= overcurrent_threshold_strap_i;
      vgs_ff      <= (gate_current_strap_a_i == IDRV_VGS_LVL) ||
                     (gate_current_strap_b_i == IDRV_VGS_LVL);
      unique case (deadtime_mode_strap_i)
        DTM_TWO_NODT: begin
          mode_ff <= HBGC_TWO_IN;
          dt_ff   <= DT_ZERO;
        end
        DTM_ONE_MIN: begin
          mode_ff <= HBGC_ONE_IN;
          dt_ff   <= DT_MIN_C;
        end
        DTM_INDEP: begin
          mode_ff <= HBGC_INDEP;
          dt_ff   <= DT_ZERO;
        end
        DTM_TWO_ADJ: begin
          mode_ff <= HBGC_TWO_IN;
          dt_ff   <= dt_clamp(deadtime_adjust_i);
        end
        DTM_ONE_ADJ: begin
          mode_ff <= HBGC_ONE_IN;
          dt_ff   <= dt_clamp(deadtime_adjust_i);
        end
        // unused levels fall back to the safest protected setting
        default: begin
          mode_ff <= HBGC_TWO_IN;
          dt_ff   <= DT_MIN_C;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // threshold pulse window
  // ----------------------------------------------------------------
  // exactly one pulse counts; a second one is read as a noisy strap
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      win_cnt_ff   <= '0;
      pulse_cnt_ff <= 2'h0;
      pulse_d_ff   <= 1'b0;
      ocp_done_ff  <= 1'b0;
      ocp_th_ff    <= '0;
      hs_ocp_ff    <= 1'b0;
      ls_ocp_ff    <= 1'b0;
    end else begin
      pulse_d_ff <= overcurrent_threshold_pulse_i;
      if (cfg_done_ff && !ocp_done_ff) begin
        win_cnt_ff <= win_cnt_ff + 16'h0001;
        if (overcurrent_threshold_pulse_i && !pulse_d_ff &&
            pulse_cnt_ff != 2'h3) begin
          pulse_cnt_ff <= pulse_cnt_ff + 2'h1;
        end
        if (win_cnt_ff >= 16'(WIN_CYC)) begin
          ocp_done_ff <= 1'b1;
          if (pulse_cnt_ff == 2'h1 && ocp_lvl_ff < OCP_EXT_NUM) begin
            ocp_th_ff <= OCP_EXT_BASE + {1'b0, ocp_lvl_ff};
          end else begin
            ocp_th_ff <= {1'b0, ocp_lvl_ff};
          end
          hs_ocp_ff <= (ocp_lvl_ff != OCP_LVL_OPEN);
          ls_ocp_ff <= (ocp_lvl_ff != OCP_LVL_OPEN) &&
                       (mode_ff != HBGC_INDEP);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // amplifier gain follows its strap
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      gain_ff <= '0;
    end else begin
      gain_ff <= amp_gain_strap_i;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent latch and fault pin
  // ----------------------------------------------------------------
  assign both_low  = !pwm_primary_in_i && !pwm_secondary_in_i;
  assign clr_done  = both_low && (clr_cnt_ff >= 16'(CLR_CYC - 1));
  assign fault_any = ocp_lat_ff || fault_detect_i;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ocp_lat_ff <= 1'b0;
      clr_cnt_ff <= '0;
    end else begin
      if (!ocp_lat_ff || !both_low) begin
        clr_cnt_ff <= '0;
      end else if (!clr_done) begin
        clr_cnt_ff <= clr_cnt_ff + 16'h0001;
      end
      // a new event in the clearing cycle keeps the latch set
      if (ocp_event_i && (hs_ocp_ff || ls_ocp_ff)) begin
        ocp_lat_ff <= 1'b1;
      end else if (clr_done) begin
        ocp_lat_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fault_oe_n_ff <= 1'b1;
      fault_lvl_ff  <= 1'b0;
    end else begin
      fault_oe_n_ff <= !fault_any;
      fault_lvl_ff  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pwm decode
  // ----------------------------------------------------------------
  always_comb begin
    hs_req = 1'b0;
    ls_req = 1'b0;
    unique case (mode_ff)
      HBGC_TWO_IN: begin
        // both high or both low leave the node floating
        hs_req = pwm_primary_in_i && !pwm_secondary_in_i;
        ls_req = pwm_secondary_in_i && !pwm_primary_in_i;
      end
      HBGC_ONE_IN: begin
        hs_req = pwm_secondary_in_i && pwm_primary_in_i;
        ls_req = pwm_secondary_in_i && !pwm_primary_in_i;
      end
      HBGC_INDEP: begin
        hs_req = pwm_primary_in_i;
        ls_req = pwm_secondary_in_i;
      end
    endcase
  end

  hbgc_dt_gate u_hs_dt (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .req_i         (hs_req),
    .opp_on_i      (lg_ff),
    .vgs_mode_i    (vgs_ff),
    .opp_vgs_low_i (ls_vgs_low_i),
    .dt_cyc_i      (dt_ff),
    .on_o          (hs_dt_on)
  );

  hbgc_dt_gate u_ls_dt (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .req_i         (ls_req),
    .opp_on_i      (hg_ff),
    .vgs_mode_i    (vgs_ff),
    .opp_vgs_low_i (hs_vgs_low_i),
    .dt_cyc_i      (dt_ff),
    .on_o          (ls_dt_on)
  );

  // ----------------------------------------------------------------
  // gate outputs
  // ----------------------------------------------------------------
  // shutdown skips the mode logic entirely so it works before config too
  assign kill = !shutdown_in_n_i ||
                (SHARED_PIN && !shared_fault_shutdown_n_i) ||
                fault_any || !cfg_done_ff;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hg_ff <= 1'b0;
      lg_ff <= 1'b0;
    end else if (kill) begin
      hg_ff <= 1'b0;
      lg_ff <= 1'b0;
    end else if (mode_ff == HBGC_INDEP) begin
      hg_ff <= hs_req;
      lg_ff <= ls_req;
    end else begin
      hg_ff <= hs_dt_on && hs_req;
      lg_ff <= ls_dt_on && ls_req;
    end
  end

  // ----------------------------------------------------------------
  // trickle pump
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tcp_cnt_ff <= '0;
      tcp_ff     <= 1'b0;
    end else if (mode_ff == HBGC_INDEP && cfg_done_ff) begin
      tcp_cnt_ff <= '0;
      tcp_ff     <= 1'b1;
    end else if (pwm_secondary_in_i) begin
      tcp_cnt_ff <= '0;
      tcp_ff     <= 1'b0;
    end else if (tcp_cnt_ff >= 18'(TCP_CYC - 1)) begin
      tcp_ff     <= 1'b1;
    end else begin
      tcp_cnt_ff <= tcp_cnt_ff + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign high_gate_out_o    = hg_ff;
  assign low_gate_out_o     = lg_ff;
  assign trickle_pump_o     = tcp_ff;
  assign mode_o             = mode_ff;
  assign deadtime_cyc_o     = dt_ff;
  assign vgs_deadtime_o     = vgs_ff;
  assign gate_current_a_o   = ida_ff;
  assign gate_current_b_o   = idb_ff;
  assign ocp_threshold_o    = ocp_th_ff;
  assign hs_ocp_en_o        = hs_ocp_ff;
  assign ls_ocp_en_o        = ls_ocp_ff;
  assign amp_gain_o         = gain_ff;
  assign cfg_done_o         = cfg_done_ff;
  assign fault_out_n_o      = fault_lvl_ff;
  assign fault_out_n_oe_n_o = fault_oe_n_ff;

endmodule

// >>> tb/hbgc_properties.sv
// Purpose: port-level properties of the gate control block
// Assumes: one clock, synchronous active-low reset
// Notes:   watches a subset of the top ports only
`timescale 1ns/1ps

module hbgc_checker
  import hbgc_pkg::*;
#(
  parameter bit SHARED_PIN = 1'b0
)
(
  // clock and reset
  input wire logic            core_clk_i,
  input wire logic            rst_n_i,
  // inputs watched
  input wire logic            pwm_primary_in_i,
  input wire logic            pwm_secondary_in_i,
  input wire logic            shutdown_in_n_i,
  input wire logic            shared_fault_shutdown_n_i,
  input wire logic            ocp_event_i,
  input wire logic            fault_detect_i,
  // outputs watched
  input wire logic            high_gate_out_o,
  input wire logic            low_gate_out_o,
  input wire logic            trickle_pump_o,
  input wire logic [1:0]      mode_o,
  input wire logic [DT_W-1:0] deadtime_cyc_o,
  input wire logic            vgs_deadtime_o,
  input wire logic [2:0]      gate_current_a_o,
  input wire logic            ls_ocp_en_o,
  input wire logic            cfg_done_o,
  input wire logic            fault_out_n_o,
  input wire logic            fault_out_n_oe_n_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // timed dead time only; vgs mode may turn on earlier by design
  sequence ls_fall_s;
    mode_o != 2'h2 && !vgs_deadtime_o && deadtime_cyc_o != 7'h00
      && $fell(low_gate_out_o);
  endsequence

  // kill sources quiet now; ocp event also one cycle ago (ocp latches a cycle late)
  sequence quiet_s;
    mode_o == 2'h2 && $past(cfg_done_o) && shutdown_in_n_i
      && shared_fault_shutdown_n_i && !fault_detect_i
      && fault_out_n_oe_n_o && !ocp_event_i && !$past(ocp_event_i);
  endsequence

  shutdown_kill_a: assert property (!shutdown_in_n_i |=>
    !high_gate_out_o && !low_gate_out_o) else $error("gate on in shutdown");
  shared_kill_a: assert property (SHARED_PIN &&
    !shared_fault_shutdown_n_i |=> !high_gate_out_o && !low_gate_out_o)
    else $error("gate on with shared pin low");
  no_overlap_a: assert property (mode_o != 2'h2 |->
    !(high_gate_out_o && low_gate_out_o)) else $error("both gates on");
  dead_gap_a: assert property (ls_fall_s |->
    !high_gate_out_o [*3]) else $error("high gate on inside dead time");
  indep_direct_a: assert property (quiet_s |=>
    high_gate_out_o == $past(pwm_primary_in_i)
    && low_gate_out_o == $past(pwm_secondary_in_i))
    else $error("independent gate does not follow input");
  pump_indep_a: assert property (mode_o == 2'h2 [*3] |->
    trickle_pump_o) else $error("pump off in independent mode");
  fault_pin_a: assert property (fault_detect_i |=>
    !fault_out_n_oe_n_o && !fault_out_n_o)
    else $error("fault pin not pulled low");
  cfg_hold_a: assert property ($past(cfg_done_o) |->
    $stable(mode_o) && $stable(deadtime_cyc_o)
    && $stable(gate_current_a_o)) else $error("latched strap changed");
  ls_ocp_off_a: assert property (mode_o == 2'h2 |->
    !ls_ocp_en_o) else $error("low-side monitor on in independent");
endmodule

bind hbgc_top hbgc_checker #(.SHARED_PIN(SHARED_PIN)) u_chk (
  .core_clk_i, .rst_n_i, .pwm_primary_in_i, .pwm_secondary_in_i,
  .shutdown_in_n_i, .shared_fault_shutdown_n_i, .ocp_event_i,
  .fault_detect_i, .high_gate_out_o, .low_gate_out_o, .trickle_pump_o,
  .mode_o, .deadtime_cyc_o, .vgs_deadtime_o, .gate_current_a_o,
  .ls_ocp_en_o, .cfg_done_o, .fault_out_n_o, .fault_out_n_oe_n_o);

// >>> tb/hbgc_ctrl_model.sv
// Purpose: motor controller model driving the two pwm lines
// Assumes: requests come from the bench as levels
// Notes:   lines change just after a rising edge, like a real timer output
`timescale 1ns/1ps

module hbgc_ctrl_model (
  // clock
  input  wire logic core_clk_i,
  // requests
  input  wire logic hs_req_i,
  input  wire logic ls_req_i,
  // pwm lines
  output logic      pwm_primary_in_o,
  output logic      pwm_secondary_in_o
);
  // ----------------------------------------------------------------
  // pwm drive
  // ----------------------------------------------------------------
  initial begin
    pwm_primary_in_o = 1'b0;
    pwm_secondary_in_o = 1'b0;
  end
  // secondary is the enable in single-in mode, held high unless hi-z
  // both held low for as long as asked, so a latched fault can clear
  // requests are taken at the edge, so the bench's own writes never race
  always @(posedge core_clk_i) begin
    pwm_primary_in_o <= #1 hs_req_i;
    pwm_secondary_in_o <= #1 ls_req_i;
  end
endmodule

// >>> tb/test_half_bridge_gate_control.sv
// Purpose: self-checking bench of the gate control block
// Assumes: short counts via parameters; shared pin variant enabled
// Notes:   table rows cover modes, hand tests cover latches and faults
`timescale 1ns/1ps

module test_half_bridge_gate_control;
  import hbgc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TRICKLE_PUMP = 20;
  localparam int CLR = 5;
  localparam int WIN = 10;
  // {strap, {pwm pri, sec}, mode, {high gate, low gate}}
  localparam logic [8:0] ROWS [17] = '{
    {3'h0,2'h2,2'h0,2'h2}, {3'h0,2'h1,2'h0,2'h1}, {3'h0,2'h3,2'h0,2'h0},
    {3'h0,2'h0,2'h0,2'h0}, {3'h2,2'h3,2'h1,2'h2}, {3'h2,2'h1,2'h1,2'h1},
    {3'h2,2'h2,2'h1,2'h0}, {3'h2,2'h0,2'h1,2'h0}, {3'h3,2'h3,2'h2,2'h3},
    {3'h3,2'h2,2'h2,2'h2}, {3'h3,2'h1,2'h2,2'h1}, {3'h3,2'h0,2'h2,2'h0},
    {3'h4,2'h1,2'h0,2'h1}, {3'h4,2'h2,2'h0,2'h2}, {3'h5,2'h1,2'h1,2'h1},
    {3'h1,2'h1,2'h0,2'h1}, {3'h6,2'h2,2'h0,2'h2}};
  logic                clk, rst_n, hs, ls, pri, sec, sd_n, sh_n, pls;
  logic                ev, fd, gh, gl, pump, vgs, hso, lso, done, fo, oe_n;
  logic [STRAP_W-1:0]  dtm, gca, gcb, ocs, ia, ib;
  logic [DT_W-1:0]     dtc, adj;
  logic                hs_vl, ls_vl;
  logic [GAIN_W-1:0]   gain, gain_o;
  logic [1:0]          mode;
  logic [OCP_TH_W-1:0] th;
  int                  error_cnt, n_compared, i;

  hbgc_ctrl_model PCM (.core_clk_i(clk), .hs_req_i(hs), .ls_req_i(ls),
    .pwm_primary_in_o(pri), .pwm_secondary_in_o(sec));

  hbgc_top #(.TCP_CYC(TRICKLE_PUMP), .CLR_CYC(CLR), .WIN_CYC(WIN),
    .SHARED_PIN(1'b1)) DUT (
    .core_clk_i(clk), .rst_n_i(rst_n), .pwm_primary_in_i(pri),
    .pwm_secondary_in_i(sec), .shutdown_in_n_i(sd_n),
    .shared_fault_shutdown_n_i(sh_n), .deadtime_mode_strap_i(dtm),
    .deadtime_adjust_i(adj), .gate_current_strap_a_i(gca),
    .gate_current_strap_b_i(gcb), .overcurrent_threshold_strap_i(ocs),
    .overcurrent_threshold_pulse_i(pls), .amp_gain_strap_i(gain),
    .hs_vgs_low_i(hs_vl), .ls_vgs_low_i(ls_vl), .ocp_event_i(ev),
    .fault_detect_i(fd), .high_gate_out_o(gh), .low_gate_out_o(gl),
    .trickle_pump_o(pump), .mode_o(mode), .deadtime_cyc_o(dtc),
    .vgs_deadtime_o(vgs), .gate_current_a_o(ia), .gate_current_b_o(ib),
    .ocp_threshold_o(th), .hs_ocp_en_o(hso), .ls_ocp_en_o(lso),
    .amp_gain_o(gain_o), .cfg_done_o(done), .fault_out_n_o(fo),
    .fault_out_n_oe_n_o(oe_n));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [DT_W-1:0] exp_dt(input logic [2:0] s);
    if (s == 3'h0 || s == 3'h3) return 7'h00;
    if (s == 3'h4 || s == 3'h5) return 7'h14;
    return 7'h03;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // straps are sampled on the first edge after release; pulse after it
  task automatic do_reset(input logic p);
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    pls = p;
    cyc(1);
    pls = 1'b0;
    cyc(WIN);
  endtask

  // bounded wait: 0 watches the fault enable, 1 the pump
  task automatic wait_for(input int sel, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      if ((sel == 0 ? oe_n : pump) === v) return;
      cyc(1);
    end
    error_cnt++;
    $display("ERROR at %0t: seen %h expected %h", $time, ~v, v);
    report_and_stop();
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, hs, ls, pls, ev, fd} = 6'h00;
    {sd_n, sh_n} = 2'h3;
    {dtm, gca, gcb, ocs, gain} = 14'h0;
    {hs_vl, ls_vl, adj} = {2'h3, 7'h14};
    error_cnt = 0;
    n_compared = 0;
    for (i = 0; i < 17; i++) begin
      if (i == 0 || ROWS[i][8:6] !== ROWS[i-1][8:6]) begin
        dtm = ROWS[i][8:6];
        do_reset(1'b0);
        chk(mode, ROWS[i][3:2]);
        chk(dtc, exp_dt(dtm));
      end
      {hs, ls} = ROWS[i][5:4];
      cyc(exp_dt(dtm) + 8);
      chk({gh, gl}, ROWS[i][1:0]);
    end
    $display("mode table done");
    {dtm, gca, gcb, ocs} = {DTM_INDEP, 3'h7, 3'h5, 3'h2};
    do_reset(1'b1);
    chk({vgs, ia, ib}, 7'h7d);
    chk({th, hso, lso, pump}, 7'h4d);
    {dtm, gca, ocs, gain} = {DTM_TWO_NODT, 3'h0, 3'h7, 2'h3};
    {hs, ls} = 2'h3;
    cyc(4);
    chk({mode, ia, th}, 9'h179);
    chk({gh, gl, gain_o}, 4'hf);
    sd_n = 1'b0;
    cyc(2);
    chk({gh, gl}, 2'h0);
    {sd_n, sh_n} = 2'h2;
    cyc(2);
    chk({gh, gl}, 2'h0);
    sh_n = 1'b1;
    $display("latch and shutdown done");
    do_reset(1'b0);
    {ev, hs, ls} = 3'h4;
    cyc(1);
    ev = 1'b0;
    cyc(3);
    chk({hso, lso, oe_n}, 3'h1);
    ocs = 3'h3;
    do_reset(1'b0);
    chk({th, hso, lso}, 6'h0f);
    hs = 1'b1;
    cyc(6);
    ev = 1'b1;
    cyc(1);
    ev = 1'b0;
    cyc(2);
    chk({gh, gl, oe_n}, 3'h0);
    cyc(CLR + 4);
    chk(oe_n, 1'b0);
    hs = 1'b0;
    cyc(2);
    chk(oe_n, 1'b0);
    wait_for(0, 1'b1, CLR + 10);
    chk(oe_n, 1'b1);
    fd = 1'b1;
    cyc(2);
    chk(oe_n, 1'b0);
    fd = 1'b0;
    cyc(3);
    chk(oe_n, 1'b1);
    $display("fault tests done");
    ls = 1'b1;
    cyc(4);
    chk(pump, 1'b0);
    ls = 1'b0;
    cyc(TRICKLE_PUMP - 4);
    chk(pump, 1'b0);
    wait_for(1, 1'b1, 10);
    chk(pump, 1'b1);
    $display("pump test done");
    {gca, ls_vl} = {3'h7, 1'b0};
    do_reset(1'b0);
    chk({done, vgs}, 2'h3);
    hs = 1'b1;
    cyc(6);
    chk(gh, 1'b0);
    ls_vl = 1'b1;
    cyc(3);
    chk(gh, 1'b1);
    {hs, dtm, gca, adj} = {1'b0, DTM_TWO_ADJ, 3'h0, 7'h7f};
    do_reset(1'b0);
    chk(dtc, 7'h70);
    adj = 7'h01;
    do_reset(1'b0);
    chk(dtc, 7'h03);
    $display("vgs and dead time range done");
    report_and_stop();
  end
endmodule
